// file: rtl/move_const_pkg.sv
// constants for the move, constant, negate, idle and normalize execution block
package move_const_pkg;
	localparam int          WORD_W        = 32;
	localparam int          LONG_W        = 40;
	localparam int          REG_AW        = 5;
	localparam int          DELAY_SLOTS   = 3;
	// opcode field positions
	localparam int          CREG_HI       = 31;
	localparam int          CREG_LO       = 29;
	localparam int          ZBIT_POS      = 28;
	localparam int          DST_HI        = 27;
	localparam int          DST_LO        = 23;
	localparam int          SRCB_HI       = 22;
	localparam int          SRCB_LO       = 18;
	localparam int          SRC1_HI       = 17;
	localparam int          SRC1_LO       = 13;
	localparam int          WIDE_CST_HI   = 22;
	localparam int          WIDE_CST_LO   = 7;
	localparam int          OPF_HI        = 11;
	localparam int          OPF_LO        = 5;
	localparam int          IDLE_HI       = 16;
	localparam int          IDLE_LO       = 13;
	localparam int          HALF_W        = 16;
	// long-form opfield codes of the logical unit
	localparam logic [6:0]  OPF_NEG32     = 7'h06;
	localparam logic [6:0]  OPF_NEG40     = 7'h24;
	localparam logic [6:0]  OPF_NORM32    = 7'h63;
	localparam logic [6:0]  OPF_NORM40    = 7'h60;
	localparam logic [3:0]  IDLE_MAX      = 4'h8;
	// operation selected by dispatch
	typedef enum logic [3:0] {
		OP_NONE        = 4'h0,
		OP_DMOVE       = 4'h1,
		OP_CONST_S     = 4'h2,
		OP_CONST_L     = 4'h3,
		OP_CONST_D     = 4'h4,
		OP_CONST_LOW   = 4'h5,
		OP_CONST_HIGH  = 4'h6,
		OP_LOW_TO_HIGH = 4'h7,
		OP_NEGATE_S    = 4'h8,
		OP_NEGATE_L    = 4'h9,
		OP_NORM        = 4'ha,
		OP_IDLE        = 4'hb
	} op_sel_t;
	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_IDLE = 2'b10
	} idle_state_t;
endpackage

// file: rtl/sign_bit_counter.sv
// counts redundant sign bits of a 40-bit operand
`timescale 1ns/1ns
`default_nettype none
module sign_bit_counter
	import move_const_pkg::*;
(
	input  wire logic [LONG_W-1:0] operand,
	input  wire logic              is_long,
	output logic      [5:0]        count
);
	logic [LONG_W-1:0] ext;
	logic [LONG_W-1:0] same;
	logic [5:0]        run;
	logic [5:0]        limit;

	// a 32-bit operand is sign extended so the top 8 bits always match
	always_comb begin
		ext = is_long ? operand : {{(LONG_W-WORD_W){operand[WORD_W-1]}}, operand[WORD_W-1:0]};
	end

	genvar gi;
	generate
		for (gi = 0; gi < LONG_W - 1; gi++) begin : g_same
			assign same[gi] = ext[gi] == ext[LONG_W-1];
		end
	endgenerate
	assign same[LONG_W-1] = 1'b0;

	always_comb begin
		run = 6'h00;
		for (int i = LONG_W - 2; i >= 0; i--) begin
			if (same[i] && run == 6'(LONG_W - 2 - i)) begin
				run = run + 6'h01;
			end
		end
		limit = is_long ? 6'(LONG_W - 1) : 6'(WORD_W - 1);
		count = is_long ? run : ((run >= 6'(LONG_W - WORD_W)) ? run - 6'(LONG_W - WORD_W) : 6'h00);
		if (count > limit) begin
			count = limit;
		end
	end
endmodule
`default_nettype wire

// file: rtl/move_const_exec.sv
// execution of delayed move, constant loads, negate, idle and normalize
// Contract
// - delayed move reads source in E1, writes destination in E4
// - shift-unit constant load sign extends 16-bit field to 32 bits
// - logical/data unit constant load uses 5-bit signed field; data unit in src1 slot
// - upper-half load replaces upper 16 bits, keeps lower 16 bits
// - low constant load sign extends 16-bit field
// - constant loads write in E2, read no source register
// - negate is zero minus source; 32-bit and 40-bit logical forms
// - idle lasts field plus one cycles, up to nine
// - multicycle idle ends when an earlier branch completes
// - normalize writes redundant sign bit count, 32 and 40-bit forms
`timescale 1ns/1ns
`default_nettype none
module move_const_exec
	import move_const_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              issue_valid,
	input  wire logic [WORD_W-1:0] opcode,
	input  wire op_sel_t           op_sel,
	input  wire logic              cond_true,
	input  wire logic [WORD_W-1:0] src_lo,
	input  wire logic [WORD_W-1:0] src_hi,
	input  wire logic [WORD_W-1:0] dst_old,
	input  wire logic              branch_done,
	output logic                   src_read,
	output logic [REG_AW-1:0]      src_addr,
	output logic                   wr_en,
	output logic [REG_AW-1:0]      wr_addr,
	output logic [WORD_W-1:0]      wr_data,
	output logic                   wr_hi_en,
	output logic [LONG_W-WORD_W-1:0] wr_hi_data,
	output logic                   idle_busy,
	output logic                   idle_is_op,
	output logic                   idle_parallel
);
	// delay line for the delayed move through the multiplier path
	logic [DELAY_SLOTS-1:0] mv_vld_q, mv_vld_d;
	logic [WORD_W-1:0]      mv_data_q [DELAY_SLOTS];
	logic [WORD_W-1:0]      mv_data_d [DELAY_SLOTS];
	logic [REG_AW-1:0]      mv_addr_q [DELAY_SLOTS];
	logic [REG_AW-1:0]      mv_addr_d [DELAY_SLOTS];
	// single-cycle result registers
	logic                   wr_en_q, wr_en_d;
	logic [REG_AW-1:0]      wr_addr_q, wr_addr_d;
	logic [WORD_W-1:0]      wr_data_q, wr_data_d;
	logic                   wr_hi_en_q, wr_hi_en_d;
	logic [LONG_W-WORD_W-1:0] wr_hi_q, wr_hi_d;
	// idle counter
	idle_state_t            st_q, st_d;
	logic [3:0]             idle_cnt_q, idle_cnt_d;

	logic [REG_AW-1:0]      dst_f;
	logic [HALF_W-1:0]      wide_cst;
	logic [4:0]             cst5_srcb;
	logic [4:0]             cst5_src1;
	logic [6:0]             opf;
	logic [3:0]             idle_fld;
	logic                   idle_dec;
	logic [LONG_W-1:0]      long_src;
	logic [LONG_W-1:0]      negate_res;
	logic [5:0]             norm_cnt;
	logic                   exec;

	assign dst_f     = opcode[DST_HI:DST_LO];
	assign wide_cst  = opcode[WIDE_CST_HI:WIDE_CST_LO];
	assign cst5_srcb = opcode[SRCB_HI:SRCB_LO];
	assign cst5_src1 = opcode[SRC1_HI:SRC1_LO];
	assign opf       = opcode[OPF_HI:OPF_LO];
	assign idle_fld  = opcode[IDLE_HI:IDLE_LO];
	assign long_src  = {src_hi[LONG_W-WORD_W-1:0], src_lo};
	assign exec      = issue_valid && cond_true;

	// idle pattern: all fields zero apart from the count and the parallel bit
	assign idle_dec = opcode[CREG_HI:IDLE_HI+1] == '0 && opcode[IDLE_LO-1:1] == '0;
	assign idle_is_op    = issue_valid && idle_dec;
	assign idle_parallel = opcode[0];

	sign_bit_counter sign_bit_counter_inst (
		.operand (long_src),
		.is_long (opf == OPF_NORM40),
		.count   (norm_cnt)
	);

	assign negate_res = (opf == OPF_NEG40) ? LONG_W'(0) - long_src
		: {{(LONG_W-WORD_W){1'b0}}, WORD_W'(0) - src_lo};

	// source read in E1 only for ops that have one; constant loads read no source, the upper-half loads read dst_old
	always_comb begin
		src_read = issue_valid && (op_sel == OP_DMOVE || op_sel == OP_NEGATE_S
			|| op_sel == OP_NEGATE_L || op_sel == OP_NORM);
		src_addr = opcode[SRCB_HI:SRCB_LO];
	end

	always_comb begin
		wr_en_d    = 1'b0;
		wr_addr_d  = dst_f;
		wr_data_d  = '0;
		wr_hi_en_d = 1'b0;
		wr_hi_d    = '0;
		if (exec && st_q == ST_RUN) begin
			case (op_sel)
				OP_CONST_S, OP_CONST_LOW: begin
					wr_en_d   = 1'b1;
					wr_data_d = {{HALF_W{wide_cst[HALF_W-1]}}, wide_cst};
				end
				OP_CONST_L: begin
					wr_en_d   = 1'b1;
					wr_data_d = {{(WORD_W-5){cst5_srcb[4]}}, cst5_srcb};
				end
				OP_CONST_D: begin
					wr_en_d   = 1'b1;
					wr_data_d = {{(WORD_W-5){cst5_src1[4]}}, cst5_src1};
				end
				OP_CONST_HIGH, OP_LOW_TO_HIGH: begin
					wr_en_d   = 1'b1;
					wr_data_d = {wide_cst, dst_old[HALF_W-1:0]};
				end
				OP_NEGATE_S, OP_NEGATE_L: begin
					wr_en_d    = 1'b1;
					wr_data_d  = negate_res[WORD_W-1:0];
					wr_hi_en_d = op_sel == OP_NEGATE_L && opf == OPF_NEG40;
					wr_hi_d    = negate_res[LONG_W-1:WORD_W];
				end
				OP_NORM: begin
					wr_en_d   = 1'b1;
					wr_data_d = {{(WORD_W-6){1'b0}}, norm_cnt};
				end
				default: begin
					wr_en_d = 1'b0;
				end
			endcase
		end
	end

	// delay line: stage 0 captured in E1, written out in E4
	always_comb begin
		mv_vld_d     = {mv_vld_q[DELAY_SLOTS-2:0], exec && op_sel == OP_DMOVE && st_q == ST_RUN};
		mv_data_d[0] = src_lo;
		mv_addr_d[0] = dst_f;
		for (int i = 1; i < DELAY_SLOTS; i++) begin
			mv_data_d[i] = mv_data_q[i-1];
			mv_addr_d[i] = mv_addr_q[i-1];
		end
	end

	// idle: count field+1 cycles, cut short when a branch completes
	always_comb begin
		st_d       = st_q;
		idle_cnt_d = idle_cnt_q;
		case (st_q)
			ST_RUN: begin
				// zero field is one idle cycle and leaves parallel ops untouched
				if (issue_valid && op_sel == OP_IDLE && idle_fld != 4'h0 && !branch_done) begin
					st_d       = ST_IDLE;
					idle_cnt_d = (idle_fld > IDLE_MAX) ? IDLE_MAX : idle_fld;
				end
			end
			ST_IDLE: begin
				if (branch_done || idle_cnt_q == 4'h1) begin
					st_d       = ST_RUN;
					idle_cnt_d = 4'h0;
				end else begin
					idle_cnt_d = idle_cnt_q - 4'h1;
				end
			end
			default: begin
				st_d       = ST_RUN;
				idle_cnt_d = 4'h0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mv_vld_q   <= '0;
			wr_en_q    <= 1'b0;
			wr_addr_q  <= '0;
			wr_data_q  <= '0;
			wr_hi_en_q <= 1'b0;
			wr_hi_q    <= '0;
			st_q       <= ST_RUN;
			idle_cnt_q <= 4'h0;
			for (int i = 0; i < DELAY_SLOTS; i++) begin
				mv_data_q[i] <= '0;
				mv_addr_q[i] <= '0;
			end
		end else begin
			mv_vld_q   <= mv_vld_d;
			wr_en_q    <= wr_en_d;
			wr_addr_q  <= wr_addr_d;
			wr_data_q  <= wr_data_d;
			wr_hi_en_q <= wr_hi_en_d;
			wr_hi_q    <= wr_hi_d;
			st_q       <= st_d;
			idle_cnt_q <= idle_cnt_d;
			for (int i = 0; i < DELAY_SLOTS; i++) begin
				mv_data_q[i] <= mv_data_d[i];
				mv_addr_q[i] <= mv_addr_d[i];
			end
		end
	end

	// delayed move output wins the write port in E4
	always_comb begin
		if (mv_vld_q[DELAY_SLOTS-1]) begin
			wr_en      = 1'b1;
			wr_addr    = mv_addr_q[DELAY_SLOTS-1];
			wr_data    = mv_data_q[DELAY_SLOTS-1];
			wr_hi_en   = 1'b0;
			wr_hi_data = '0;
		end else begin
			wr_en      = wr_en_q;
			wr_addr    = wr_addr_q;
			wr_data    = wr_data_q;
			wr_hi_en   = wr_hi_en_q;
			wr_hi_data = wr_hi_q;
		end
	end

	assign idle_busy = st_q == ST_IDLE;
endmodule
`default_nettype wire

// file: verif/regfile_model.sv
// register file standing in for the dispatch side of the block
`timescale 1ns/1ns
`default_nettype none
module regfile_model
	import move_const_pkg::*;
(
	input  wire logic              clk,
	input  wire logic [REG_AW-1:0] src_addr,
	input  wire logic [REG_AW-1:0] dst_addr,
	input  wire logic              wr_en,
	input  wire logic [REG_AW-1:0] wr_addr,
	input  wire logic [WORD_W-1:0] wr_data,
	input  wire logic              wr_hi_en,
	input  wire logic [7:0]        wr_hi_data,
	output logic      [WORD_W-1:0] src_lo,
	output logic      [WORD_W-1:0] src_hi,
	output logic      [WORD_W-1:0] dst_old
);
	logic [WORD_W-1:0] r [32];
	assign src_lo  = r[src_addr];
	assign src_hi  = r[src_addr + 5'h1];
	assign dst_old = r[dst_addr];
	task automatic load(input logic [REG_AW-1:0] a, input logic [WORD_W-1:0] v);
		r[a] = v;
	endtask
	// upper byte of a long result lands in the odd register of the pair
	always @(posedge clk) begin
		if (wr_en)
			r[wr_addr] <= wr_data;
		if (wr_hi_en)
			r[wr_addr + 5'h1] <= {24'h0, wr_hi_data};
	end
endmodule
`default_nettype wire

// file: verif/move_const_exec_monitor.sv
// concurrent checks on the move, constant, negate, idle and normalize block
`timescale 1ns/1ns
`default_nettype none
module move_const_exec_monitor
	import move_const_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              issue_valid,
	input wire logic [WORD_W-1:0] opcode,
	input wire op_sel_t           op_sel,
	input wire logic              cond_true,
	input wire logic [WORD_W-1:0] src_lo,
	input wire logic [WORD_W-1:0] dst_old,
	input wire logic              branch_done,
	input wire logic              src_read,
	input wire logic              wr_en,
	input wire logic [WORD_W-1:0] wr_data,
	input wire logic              idle_busy,
	input wire logic              idle_is_op,
	input wire logic              idle_parallel
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic go;
	assign go = issue_valid && !idle_busy;
	sequence s_take(op_sel_t op);
		go && cond_true && op_sel == op;
	endsequence
	sequence s_busy4;
		idle_busy [*4] ##1 !idle_busy;
	endsequence
	chk_dmove_delay: assert property (
		s_take(OP_DMOVE) |-> ##3 (wr_en && wr_data == $past(src_lo, 3)))
		else $error("delayed move result wrong");
	chk_wide_const: assert property (
		s_take(OP_CONST_S) |=> wr_en && wr_data == {{16{$past(opcode[22])}}, $past(opcode[22:7])})
		else $error("wide constant wrong");
	chk_low_const: assert property (
		s_take(OP_CONST_LOW) |=> wr_en && $signed(wr_data) == $signed($past(opcode[22:7])))
		else $error("low constant wrong");
	chk_upper_half: assert property (
		s_take(OP_CONST_HIGH) |=> wr_en && wr_data == {$past(opcode[22:7]), $past(dst_old[15:0])})
		else $error("upper half load wrong");
	chk_negate_value: assert property (
		s_take(OP_NEGATE_S) |=> wr_en && wr_data == 32'h0 - $past(src_lo))
		else $error("negate wrong");
	chk_const_noread: assert property (
		go && op_sel inside {OP_CONST_S, OP_CONST_L, OP_CONST_D, OP_CONST_LOW} |-> !src_read)
		else $error("constant load read a source");
	chk_false_nowrite: assert property (
		go && !cond_true |=> !wr_en)
		else $error("write under false condition");
	chk_idle_single: assert property (
		go && op_sel == OP_IDLE && opcode[16:13] == 4'h0 |=> !idle_busy)
		else $error("single idle stretched");
	chk_idle_four: assert property (
		go && op_sel == OP_IDLE && opcode[16:13] == 4'h4 |=> s_busy4)
		else $error("idle length wrong");
	chk_branch_cut: assert property (
		idle_busy && branch_done |=> !idle_busy)
		else $error("idle not cut by branch");
	chk_idle_decode: assert property (
		idle_is_op == (issue_valid && opcode[31:17] == 15'h0 && opcode[12:1] == 12'h0)
		&& idle_parallel == opcode[0])
		else $error("idle decode wrong");
endmodule
`default_nettype wire

// file: verif/move_const_exec_tb.sv
// self-checking bench for the move, constant, negate, idle and normalize block
`timescale 1ns/1ns
`default_nettype none
module move_const_exec_tb;
	import move_const_pkg::*;
	logic              clk, rst_n, issue_valid, cond_true, branch_done;
	logic [WORD_W-1:0] opcode, src_lo, src_hi, dst_old, wr_data;
	op_sel_t           op_sel;
	logic              src_read, wr_en, wr_hi_en, idle_busy, idle_is_op, idle_parallel;
	logic [REG_AW-1:0] src_addr, wr_addr;
	logic [7:0]        wr_hi_data;
	int                num_errors, total_checks;
	move_const_exec move_const_exec_inst (.clk, .rst_n, .issue_valid, .opcode, .op_sel,
		.cond_true, .src_lo, .src_hi, .dst_old, .branch_done, .src_read, .src_addr, .wr_en,
		.wr_addr, .wr_data, .wr_hi_en, .wr_hi_data, .idle_busy, .idle_is_op, .idle_parallel);
	regfile_model regfile_model_inst (.clk, .src_addr, .dst_addr(opcode[27:23]), .wr_en,
		.wr_addr, .wr_data, .wr_hi_en, .wr_hi_data, .src_lo, .src_hi, .dst_old);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic drive(input op_sel_t op, input logic [31:0] opc, input logic c);
		@(posedge clk);
		#1;
		issue_valid = 1'b1;
		op_sel = op;
		opcode = opc;
		cond_true = c;
		@(posedge clk);
		#1;
		issue_valid = 1'b0;
	endtask
	task automatic run(input op_sel_t op, input logic [4:0] d, input logic [22:0] lo,
		input logic c);
		drive(op, {4'h0, d, lo}, c);
		repeat (4) @(posedge clk);
	endtask
	function automatic logic [31:0] rg(input int a);
		return regfile_model_inst.r[a];
	endfunction
	task automatic t_const();
		run(OP_CONST_S, 5'd1, {16'h8000, 7'h0}, 1'b1);
		check(rg(1), 32'hffff8000);
		run(OP_CONST_LOW, 5'd1, {16'hc678, 7'h0}, 1'b1);
		check(rg(1), 32'hffffc678);
		run(OP_CONST_HIGH, 5'd1, {16'h0a32, 7'h0}, 1'b1);
		check(rg(1), 32'h0a32c678);
		regfile_model_inst.load(5'd2, 32'hfffff25a);
		run(OP_LOW_TO_HIGH, 5'd2, {16'h07a8, 7'h0}, 1'b1);
		check(rg(2), 32'h07a8f25a);
		run(OP_CONST_L, 5'd3, {5'h1b, 18'h0}, 1'b1);
		check(rg(3), 32'hfffffffb);
		run(OP_CONST_D, 5'd4, {5'h0, 5'h0e, 13'h0}, 1'b1);
		check(rg(4), 32'h0000000e);
		run(OP_CONST_S, 5'd1, {16'h1234, 7'h0}, 1'b0);
		check(rg(1), 32'h0a32c678);
	endtask
	task automatic t_move();
		regfile_model_inst.load(5'd5, 32'h6a321193);
		drive(OP_DMOVE, {4'h0, 5'd8, 5'd5, 18'h0}, 1'b1);
		// source overwritten right after the read must not leak through
		regfile_model_inst.load(5'd5, 32'h0);
		// still unwritten one cycle before the fourth-phase write
		repeat (2) @(posedge clk);
		#1;
		check(rg(8) === 32'h6a321193, 32'h0);
		@(posedge clk);
		#1;
		check(rg(8), 32'h6a321193);
	endtask
	task automatic t_arith();
		regfile_model_inst.load(5'd6, 32'h1);
		regfile_model_inst.load(5'd7, 32'h0);
		run(OP_NEGATE_S, 5'd9, {5'd6, 18'h0}, 1'b1);
		check(rg(9), 32'hffffffff);
		run(OP_NEGATE_L, 5'd12, {5'd6, 6'h0, OPF_NEG32, 5'h0}, 1'b1);
		check(rg(12), 32'hffffffff);
		run(OP_NEGATE_L, 5'd10, {5'd6, 6'h0, OPF_NEG40, 5'h0}, 1'b1);
		check(rg(10), 32'hffffffff);
		check(rg(11), 32'h000000ff);
		regfile_model_inst.load(5'd14, 32'h02a3469f);
		regfile_model_inst.load(5'd16, 32'hfffff25a);
		regfile_model_inst.load(5'd18, 32'h7);
		regfile_model_inst.load(5'd19, 32'h0);
		run(OP_NORM, 5'd20, {5'd14, 6'h0, OPF_NORM32, 5'h0}, 1'b1);
		check(rg(20), 32'd5);
		run(OP_NORM, 5'd20, {5'd16, 6'h0, OPF_NORM32, 5'h0}, 1'b1);
		check(rg(20), 32'd19);
		run(OP_NORM, 5'd20, {5'd18, 6'h0, OPF_NORM40, 5'h0}, 1'b1);
		check(rg(20), 32'd36);
	endtask
	// only one multicycle idle is ever in flight
	task automatic t_idle(input logic [3:0] f, input int cut, input int exp);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		issue_valid = 1'b1;
		op_sel = OP_IDLE;
		opcode = {15'h0, f, 12'h0, 1'b1};
		cond_true = 1'b1;
		// idle_is_op only stands while the word is presented; idle_parallel follows opcode[0]
		#1;
		check({30'h0, idle_is_op, idle_parallel}, 32'h3);
		@(posedge clk);
		#1;
		issue_valid = 1'b0;
		for (int k = 1; k < 12; k++) begin
			branch_done = (k == cut);
			if (idle_busy === 1'b1)
				n++;
			@(posedge clk);
			#1;
		end
		branch_done = 1'b0;
		check(n, exp);
	endtask
	initial begin
		#100000;
		num_errors++;
		test_done();
	end
	initial begin
		rst_n = 1'b0;
		issue_valid = 1'b0;
		cond_true = 1'b0;
		branch_done = 1'b0;
		opcode = 32'h0;
		op_sel = OP_NONE;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_const();
		t_move();
		t_arith();
		t_idle(4'h0, 0, 0);
		t_idle(4'h4, 0, 4);
		t_idle(4'h8, 0, 8);
		t_idle(4'h8, 2, 2);
		test_done();
	end
endmodule
bind move_const_exec move_const_exec_monitor move_const_exec_monitor_inst (.clk, .rst_n,
	.issue_valid, .opcode, .op_sel, .cond_true, .src_lo, .dst_old, .branch_done, .src_read,
	.wr_en, .wr_data, .idle_busy, .idle_is_op, .idle_parallel);
`default_nettype wire
